// ==== verilog/scc_pkg.sv ====
/*
  Shared constants for the serial command checker: access addresses,
  field positions, mode encodings and reset values.
  Assumes it is compiled before every design file that names it.
*/
package scc_pkg;

  // Device operating modes
  typedef enum logic [2:0] {
    SCC_INIT     = 3'h0,
    SCC_NORMAL   = 3'h1,
    SCC_STOP     = 3'h2,
    SCC_SLEEP    = 3'h3,
    SCC_RESTART  = 3'h4,
    SCC_FAILSAFE = 3'h5
  } scc_mode_t;

  // Frame geometry
  localparam logic [5:0] FRAME_SHORT = 6'h10;
  localparam logic [5:0] FRAME_LONG = 6'h20;
  localparam logic [5:0] CNT_SAT = 6'h21;
  localparam int ADDR_LSB = 0;
  localparam int RW_BIT = 7;
  localparam int DATA_LSB = 8;

  // Access addresses (7 bits)
  localparam logic [6:0] ADDR_MODE = 7'h01;
  localparam logic [6:0] ADDR_WD = 7'h02;
  localparam logic [6:0] ADDR_BUS = 7'h03;
  localparam logic [6:0] ADDR_WAKE1 = 7'h04;
  localparam logic [6:0] ADDR_GPIO = 7'h05;
  localparam logic [6:0] ADDR_TIMER = 7'h06;
  localparam logic [6:0] ADDR_DEV_STAT = 7'h43;
  localparam logic [6:0] ADDR_WSTAT0 = 7'h46;
  localparam logic [6:0] ADDR_WSTAT1 = 7'h47;

  // Mode control byte: request field and the remaining bits
  localparam int MREQ_LSB = 6;
  localparam logic [1:0] MREQ_NORMAL = 2'h0;
  localparam logic [1:0] MREQ_SLEEP = 2'h1;
  localparam logic [1:0] MREQ_STOP = 2'h2;
  localparam logic [1:0] MREQ_SOFT_RST = 2'h3;

  // Wake control byte: measurement select and timer wake enable
  localparam int MEAS_BIT = 7;
  localparam int TIMER_WAKE_BIT = 0;

  // Timer byte: on-time high nibble, period low nibble
  localparam int TMR_ON_LSB = 4;
  localparam int TMR_PER_LSB = 0;

  // Device status byte: command error position
  localparam int CMD_ERR_BIT = 0;

  // Reset values
  localparam logic [7:0] RST_CFG = 8'h00;
  localparam logic [15:0] RST_TX = 16'h0000;
  localparam logic [5:0] RST_MCTRL = 6'h00;

endpackage : scc_pkg

// ==== verilog/scc_sync.sv ====
/*
  Two-flop level synchroniser, one stage pair per bit.
  Assumes each bit is a level that holds for at least two
  destination clock periods.
*/
`timescale 1ns/1ps
module scc_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk_i, // Destination clock
  input wire logic nrst_i, // Synchronous reset, low
  input wire logic [WIDTH-1:0] d_i, // Foreign level
  output logic [WIDTH-1:0] q_o // Synchronised level
);

  // One stage pair per bit; first stage read only by the second
  genvar g;
  generate
    for (g = 0; g < WIDTH; g++) begin : g_bit
      logic meta_reg;
      logic sync_reg;
      always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
          meta_reg <= 1'b0;
          sync_reg <= 1'b0;
        end else begin
          meta_reg <= d_i[g];
          sync_reg <= meta_reg;
        end
      end
      assign q_o[g] = sync_reg;
    end
  endgenerate

endmodule : scc_sync

// ==== verilog/scc_checker.sv ====
/*
  Serial slave with command validity checking and mode control.
  Link side runs on the master's serial clock; the rest on mclk_i.
  Assumes the serial clock is still while chip select is high and
  chip select stays high for at least four mclk_i periods.
*/
`timescale 1ns/1ps
module scc_checker (
  input wire logic mclk_i, // Core clock, 200 MHz
  input wire logic nrst_i, // Reset, low; synchronous, but asynchronous for frame_tog_reg
  input wire logic sclk_i, // Serial clock from master
  input wire logic chip_select_low_i, // Chip select, low active
  input wire logic serial_in_i, // Serial data in
  input wire logic [7:0] wake_event0_i, // Wake event pulses, group 0
  input wire logic [7:0] wake_event1_i, // Wake event pulses, group 1
  input wire logic restart_done_i, // Restart sequence finished
  input wire logic fail_safe_i, // Fail-safe entry request
  output logic serial_out_o, // Serial data out
  output logic serial_out_oe_o, // Output enable, high drives
  output logic [2:0] mode_o, // Current operating mode
  output logic cmd_error_o, // Sticky command error flag
  output logic frame_error_o, // Last frame had bad length
  output logic interrupt_out_low_o, // Interrupt pulse, low
  output logic wd_trigger_o, // Watchdog trigger pulse
  output logic soft_reset_o, // Soft reset pulse
  output logic [7:0] wd_config_o, // Watchdog settings
  output logic [7:0] bus_ctrl_o, // Bus wake control
  output logic [7:0] wake_ctrl_o, // Wake control
  output logic [7:0] gpio_ctrl_o, // Pin configuration
  output logic [7:0] timer_ctrl_o, // Timer on-time and period
  output logic [5:0] mode_ctrl_o // Other mode control bits
);

  // Link domain state
  logic [31:0] rx_reg; // Receive shift register
  logic [5:0] cnt_reg; // Clock count, saturating
  logic rx_fresh_reg; // No falling edge yet this frame
  logic frame_tog_reg; // Toggles on first edge of a frame
  logic tx_fresh_reg; // No rising edge yet this frame
  logic [3:0] tx_idx_reg; // Index of bit on the line
  logic tx_bit_reg; // Shifted output bit

  // Core domain state
  scc_pkg::scc_mode_t mode_reg; // Operating mode
  logic [6:0] rd_addr_reg; // Address the answer byte reports
  logic cs_d_reg; // Delayed synchronised chip select
  logic tog_seen_reg; // Last frame toggle seen
  logic cmd_err_reg;
  logic frame_err_reg;
  logic int_reg;
  logic wd_trig_reg;
  logic soft_rst_reg;
  logic [7:0] wd_reg;
  logic [7:0] bus_reg;
  logic [7:0] wake_reg;
  logic [7:0] gpio_reg;
  logic [7:0] timer_reg;
  logic [5:0] mctrl_reg;
  logic [7:0] wstat0_reg;
  logic [7:0] wstat1_reg;
  logic [15:0] tx_word_reg; // Answer word, stable during a frame
  logic spi_en_reg; // Interface enabled by mode

  // Falling edge: sample input, count clocks
  always_ff @(negedge sclk_i or posedge chip_select_low_i) begin
    if (chip_select_low_i) begin
      rx_fresh_reg <= 1'b1; // Set is a constant only
    end else begin
      rx_fresh_reg <= 1'b0;
    end
  end

  // Shift and count; first edge restarts the count
  always_ff @(negedge sclk_i) begin
    rx_reg <= {serial_in_i, rx_reg[31:1]};
    if (rx_fresh_reg) begin
      cnt_reg <= 6'h01;
    end else if (cnt_reg != scc_pkg::CNT_SAT) begin
      cnt_reg <= cnt_reg + 6'h01;
    end
  end

  // Frame toggle, cleared with the core so both sides start equal;
  // release is harmless because the serial clock idles during reset
  always_ff @(negedge sclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      frame_tog_reg <= 1'b0;
    end else if (rx_fresh_reg) begin
      frame_tog_reg <= ~frame_tog_reg; // Event crosses as toggle
    end
  end

  // Rising edge: step the answer word out
  always_ff @(posedge sclk_i or posedge chip_select_low_i) begin
    if (chip_select_low_i) begin
      tx_fresh_reg <= 1'b1;
    end else begin
      tx_fresh_reg <= 1'b0;
    end
  end

  // Output shifts from the answer word only, never from input
  always_ff @(posedge sclk_i) begin
    if (tx_fresh_reg) begin
      tx_idx_reg <= 4'h1;
      tx_bit_reg <= tx_word_reg[1];
    end else begin
      tx_idx_reg <= tx_idx_reg + 4'h1;
      tx_bit_reg <= tx_word_reg[tx_idx_reg + 4'h1];
    end
  end

  // Bit 0 stands before the first rising edge (error bit)
  assign serial_out_o = tx_fresh_reg ? tx_word_reg[0] : tx_bit_reg;
  // Released whenever chip select is high or mode disables the link
  assign serial_out_oe_o = ~chip_select_low_i & spi_en_reg;

  // Chip select and frame toggle into the core clock
  logic [1:0] sync_q;
  scc_sync #(.WIDTH(2)) u_sync (
    .clk_i(mclk_i),
    .nrst_i(nrst_i),
    .d_i({frame_tog_reg, ~chip_select_low_i}), // Inverted: reset value is idle
    .q_o(sync_q)
  );

  // Frame end seen in core; rx and count are still since the clock stops
  wire cs_high_s = ~sync_q[0];
  wire cs_rise = cs_high_s & ~cs_d_reg;
  wire no_clk = (sync_q[1] == tog_seen_reg);
  wire len16 = ~no_clk & (cnt_reg == scc_pkg::FRAME_SHORT);
  wire len32 = ~no_clk & (cnt_reg == scc_pkg::FRAME_LONG);
  wire len_ok = len16 | len32;
  wire len_bad = ~no_clk & ~len_ok;
  wire mode_ok = (mode_reg == scc_pkg::SCC_INIT) |
                 (mode_reg == scc_pkg::SCC_NORMAL) |
                 (mode_reg == scc_pkg::SCC_STOP);

  // Command word: short frame sits in the upper half
  wire [15:0] cmd = len16 ? rx_reg[31:16] : rx_reg[15:0];
  wire [6:0] addr = cmd[scc_pkg::ADDR_LSB +: 7];
  wire wr = cmd[scc_pkg::RW_BIT];
  wire [7:0] data = cmd[scc_pkg::DATA_LSB +: 8];
  wire stuck = len16 ? ((rx_reg[31:16] == 16'h0000) | (rx_reg[31:16] == 16'hffff))
                     : ((rx_reg == 32'h0000_0000) | (rx_reg == 32'hffff_ffff));
  wire eval = cs_rise & mode_ok & len_ok;

  // Derived conditions
  wire [1:0] mreq = data[scc_pkg::MREQ_LSB +: 2];
  wire in_stop = (mode_reg == scc_pkg::SCC_STOP);
  wire in_init = (mode_reg == scc_pkg::SCC_INIT);
  wire wake_any = (bus_reg != 8'h00) | (wake_reg != 8'h00) | (gpio_reg != 8'h00);
  wire wstat_any = (wstat0_reg != 8'h00) | (wstat1_reg != 8'h00);
  wire timer_off = (timer_reg[scc_pkg::TMR_PER_LSB +: 4] == 4'h0);
  wire timer_only = (wake_reg == (8'h01 << scc_pkg::TIMER_WAKE_BIT)) &
                    (bus_reg == 8'h00) & (gpio_reg == 8'h00);
  wire par_ok = ^data; // Odd parity expected
  wire meas_on = wake_reg[scc_pkg::MEAS_BIT];
  wire [3:0] on_t = data[scc_pkg::TMR_ON_LSB +: 4];
  wire [3:0] per_t = data[scc_pkg::TMR_PER_LSB +: 4];
  wire rd_clr_dev = eval & wr & (addr == scc_pkg::ADDR_DEV_STAT);

  // Decision for one evaluated frame
  logic err_set;
  logic int_set;
  logic trig;
  logic srst;
  logic we_wd;
  logic we_bus;
  logic we_wake;
  logic we_gpio;
  logic we_timer;
  logic we_mctrl;
  logic clr_w0;
  logic clr_w1;
  scc_pkg::scc_mode_t mode_next;
  always_comb begin
    err_set = 1'b0; // Rejections write nothing, except a sleep request without wake sources, which still writes mctrl_reg
    int_set = 1'b0;
    trig = 1'b0;
    srst = 1'b0;
    we_wd = 1'b0;
    we_bus = 1'b0;
    we_wake = 1'b0;
    we_gpio = 1'b0;
    we_timer = 1'b0;
    we_mctrl = 1'b0;
    clr_w0 = 1'b0;
    clr_w1 = 1'b0;
    mode_next = mode_reg;
    if (eval && stuck) begin
      err_set = 1'b1;
    end else if (eval && wr) begin
      if (addr == scc_pkg::ADDR_MODE) begin
        if (mreq == scc_pkg::MREQ_SOFT_RST) begin
          srst = 1'b1;
          mode_next = scc_pkg::SCC_INIT;
        end else if (in_stop && mreq == scc_pkg::MREQ_SLEEP) begin
          err_set = 1'b1;
          mode_next = scc_pkg::SCC_RESTART;
        end else if (in_init && mreq != scc_pkg::MREQ_NORMAL) begin
          err_set = 1'b1;
          mode_next = scc_pkg::SCC_NORMAL;
        end else if (in_stop && mreq == scc_pkg::MREQ_NORMAL) begin
          mode_next = scc_pkg::SCC_NORMAL;
        end else if (in_stop) begin
          err_set = (data[5:0] != mctrl_reg);
        end else if (mreq == scc_pkg::MREQ_SLEEP) begin
          we_mctrl = 1'b1;
          if (!wake_any) begin
            err_set = 1'b1;
            mode_next = scc_pkg::SCC_RESTART;
          end else begin
            mode_next = scc_pkg::SCC_SLEEP;
          end
        end else if (mreq == scc_pkg::MREQ_STOP) begin
          we_mctrl = 1'b1; // No error without wake bits
          int_set = wstat_any;
          mode_next = scc_pkg::SCC_STOP;
        end else begin
          we_mctrl = 1'b1;
        end
      end else if (addr == scc_pkg::ADDR_WD) begin
        if (!par_ok) begin
          err_set = 1'b1;
        end else if (in_stop && data != wd_reg) begin
          err_set = 1'b1;
        end else begin
          trig = 1'b1;
          we_wd = ~in_stop;
        end
      end else if (addr == scc_pkg::ADDR_WSTAT0) begin
        clr_w0 = 1'b1; // Read and clear allowed in stop
      end else if (addr == scc_pkg::ADDR_WSTAT1) begin
        clr_w1 = 1'b1;
      end else if (addr == scc_pkg::ADDR_DEV_STAT) begin
        err_set = 1'b0; // Clear handled below
      end else if (in_stop && (addr == scc_pkg::ADDR_BUS || addr == scc_pkg::ADDR_WAKE1 ||
                               addr == scc_pkg::ADDR_GPIO || addr == scc_pkg::ADDR_TIMER)) begin
        err_set = 1'b1;
      end else if (addr == scc_pkg::ADDR_BUS) begin
        we_bus = 1'b1;
      end else if (addr == scc_pkg::ADDR_WAKE1) begin
        if (data[scc_pkg::MEAS_BIT] && gpio_reg != 8'h00) begin
          err_set = 1'b1;
        end else begin
          we_wake = 1'b1;
        end
      end else if (addr == scc_pkg::ADDR_GPIO) begin
        if (meas_on && data != gpio_reg) begin
          err_set = 1'b1;
        end else begin
          we_gpio = 1'b1;
        end
      end else if (addr == scc_pkg::ADDR_TIMER) begin
        if (per_t != 4'h0 && on_t >= per_t) begin
          err_set = 1'b1;
        end else begin
          we_timer = 1'b1;
        end
      end
      // Unmapped addresses fall through silently
    end
    // Mode changes not driven by frames
    if (!eval) begin
      case (mode_reg)
        scc_pkg::SCC_SLEEP: begin
          if (timer_only && timer_off) begin
            mode_next = scc_pkg::SCC_RESTART;
          end else if (wake_event0_i != 8'h00 || wake_event1_i != 8'h00) begin
            mode_next = scc_pkg::SCC_RESTART;
          end
        end
        scc_pkg::SCC_RESTART: begin
          if (restart_done_i) begin
            mode_next = scc_pkg::SCC_NORMAL;
          end
        end
        scc_pkg::SCC_FAILSAFE: begin
          if (!fail_safe_i) begin
            mode_next = scc_pkg::SCC_RESTART;
          end
        end
        default: begin
          mode_next = mode_reg;
        end
      endcase
    end
    if (fail_safe_i) begin
      mode_next = scc_pkg::SCC_FAILSAFE;
    end
  end

  // Sticky flags: a new error wins over a clear in the same cycle
  wire cmd_err_next = err_set | (cmd_err_reg & ~rd_clr_dev);
  wire [7:0] wstat0_next = wake_event0_i | (clr_w0 ? 8'h00 : wstat0_reg);
  wire [7:0] wstat1_next = wake_event1_i | (clr_w1 ? 8'h00 : wstat1_reg);

  // Answer word for the next frame: error bit first
  logic [7:0] rd_byte;
  always_comb begin
    rd_byte = 8'h00;
    if (rd_addr_reg == scc_pkg::ADDR_WD) begin
      rd_byte = wd_reg;
    end else if (rd_addr_reg == scc_pkg::ADDR_BUS) begin
      rd_byte = bus_reg;
    end else if (rd_addr_reg == scc_pkg::ADDR_WAKE1) begin
      rd_byte = wake_reg;
    end else if (rd_addr_reg == scc_pkg::ADDR_GPIO) begin
      rd_byte = gpio_reg;
    end else if (rd_addr_reg == scc_pkg::ADDR_TIMER) begin
      rd_byte = timer_reg;
    end else if (rd_addr_reg == scc_pkg::ADDR_MODE) begin
      rd_byte = {2'h0, mctrl_reg};
    end else if (rd_addr_reg == scc_pkg::ADDR_WSTAT0) begin
      rd_byte = wstat0_reg;
    end else if (rd_addr_reg == scc_pkg::ADDR_WSTAT1) begin
      rd_byte = wstat1_reg;
    end else if (rd_addr_reg == scc_pkg::ADDR_DEV_STAT) begin
      rd_byte = 8'h00 | ({7'h00, cmd_err_reg} << scc_pkg::CMD_ERR_BIT);
    end
  end

  // Frame tracking and flags
  always_ff @(posedge mclk_i) begin
    if (!nrst_i) begin
      cs_d_reg <= 1'b1; // Idle level, so no false edge after reset
      tog_seen_reg <= 1'b0;
      cmd_err_reg <= 1'b0;
      frame_err_reg <= 1'b0;
      wstat0_reg <= scc_pkg::RST_CFG;
      wstat1_reg <= scc_pkg::RST_CFG;
    end else begin
      cs_d_reg <= cs_high_s;
      if (cs_rise) begin
        tog_seen_reg <= sync_q[1];
      end
      cmd_err_reg <= cmd_err_next;
      if (cs_rise && len_bad) begin
        frame_err_reg <= 1'b1;
      end else if (cs_rise && len_ok) begin
        frame_err_reg <= 1'b0;
      end
      wstat0_reg <= wstat0_next;
      wstat1_reg <= wstat1_next;
    end
  end

  // Configuration updates only at chip select release
  always_ff @(posedge mclk_i) begin
    if (!nrst_i) begin
      wd_reg <= scc_pkg::RST_CFG;
      bus_reg <= scc_pkg::RST_CFG;
      wake_reg <= scc_pkg::RST_CFG;
      gpio_reg <= scc_pkg::RST_CFG;
      timer_reg <= scc_pkg::RST_CFG;
      mctrl_reg <= scc_pkg::RST_MCTRL;
    end else begin
      if (we_wd) wd_reg <= data;
      if (we_bus) bus_reg <= data;
      if (we_wake) wake_reg <= data;
      if (we_gpio) gpio_reg <= data;
      if (we_timer) timer_reg <= data;
      if (we_mctrl) mctrl_reg <= data[5:0];
    end
  end

  // Mode, pulses and the answer word
  always_ff @(posedge mclk_i) begin
    if (!nrst_i) begin
      mode_reg <= scc_pkg::SCC_INIT;
      int_reg <= 1'b1;
      wd_trig_reg <= 1'b0;
      soft_rst_reg <= 1'b0;
      spi_en_reg <= 1'b0;
      tx_word_reg <= scc_pkg::RST_TX;
      rd_addr_reg <= 7'h00;
    end else begin
      mode_reg <= mode_next;
      int_reg <= ~int_set; // One-cycle low pulse
      wd_trig_reg <= trig;
      soft_rst_reg <= srst;
      spi_en_reg <= (mode_next == scc_pkg::SCC_INIT) |
                    (mode_next == scc_pkg::SCC_NORMAL) |
                    (mode_next == scc_pkg::SCC_STOP);
      // Later edges report the updated value
      if (eval) begin
        rd_addr_reg <= addr;
      end
      // Refresh only while the link is idle
      if (cs_high_s) begin
        tx_word_reg <= {rd_byte, wstat_any, 5'h00, cmd_err_next,
                        (frame_err_reg | (cs_rise & len_bad))};
      end
    end
  end

  // Outputs from flops
  assign mode_o = mode_reg;
  assign cmd_error_o = cmd_err_reg;
  assign frame_error_o = frame_err_reg;
  assign interrupt_out_low_o = int_reg;
  assign wd_trigger_o = wd_trig_reg;
  assign soft_reset_o = soft_rst_reg;
  assign wd_config_o = wd_reg;
  assign bus_ctrl_o = bus_reg;
  assign wake_ctrl_o = wake_reg;
  assign gpio_ctrl_o = gpio_reg;
  assign timer_ctrl_o = timer_reg;
  assign mode_ctrl_o = mctrl_reg;

endmodule : scc_checker

// ==== tb/scc_checker_properties.sv ====
/*
  Port checker for scc_checker: frame-end timing, sticky flags, pulses.
  Assumes chip select stays high for at least four mclk_i periods.
*/
`timescale 1ns/1ps
module scc_checker_properties (
  input wire logic mclk_i, // Core clock
  input wire logic nrst_i, // Sync reset, low
  input wire logic chip_select_low_i, // Select pin
  input wire logic serial_out_oe_o, // Output enable
  input wire logic [2:0] mode_o, // Mode
  input wire logic cmd_error_o, // Sticky error
  input wire logic frame_error_o, // Length error
  input wire logic interrupt_out_low_o, // Interrupt pulse
  input wire logic wd_trigger_o, // Trigger pulse
  input wire logic [7:0] bus_ctrl_o, // Bus wake control
  input wire logic [7:0] wd_config_o, // Watchdog settings
  input wire logic [7:0] timer_ctrl_o // Timer settings
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!nrst_i);
  // Results may only land once select has been high a while
  sequence s_cs_idle;
    $past(chip_select_low_i, 2);
  endsequence
  // Interrupt low for exactly one cycle, at stop entry
  sequence s_int_once;
    (mode_o == scc_pkg::SCC_STOP) ##1 interrupt_out_low_o;
  endsequence
  a_oe_release: assert property (chip_select_low_i |-> !serial_out_oe_o)
    else $error("output driven while deselected");
  a_oe_modes: assert property (serial_out_oe_o && $stable(mode_o) |-> mode_o <= 3'h2)
    else $error("output driven in a disabled mode");
  a_cfg_at_end: assert property ($changed({bus_ctrl_o, wd_config_o, timer_ctrl_o}) |-> s_cs_idle)
    else $error("settings changed before frame end");
  a_err_rise: assert property ($rose(cmd_error_o) |-> s_cs_idle)
    else $error("error flag rose outside frame end");
  a_err_sticky: assert property ($fell(cmd_error_o) |-> s_cs_idle)
    else $error("error flag cleared without a frame");
  a_frame_flag: assert property ($changed(frame_error_o) |-> s_cs_idle)
    else $error("frame flag moved outside frame end");
  a_int_pulse: assert property ($fell(interrupt_out_low_o) |-> s_int_once)
    else $error("interrupt pulse wrong");
  a_wd_pulse: assert property ($rose(wd_trigger_o) |-> s_cs_idle ##1 !wd_trigger_o)
    else $error("trigger pulse wrong");
endmodule : scc_checker_properties

bind scc_checker scc_checker_properties u_props (.mclk_i, .nrst_i, .chip_select_low_i,
  .serial_out_oe_o, .mode_o, .cmd_error_o, .frame_error_o, .interrupt_out_low_o,
  .wd_trigger_o, .bus_ctrl_o, .wd_config_o, .timer_ctrl_o);

// ==== tb/scc_master_model.sv ====
/*
  Serial master model: clock, select and data out, answer sampled.
  Assumes the caller spaces frames; clock stands still between them.
*/
`timescale 1ns/1ps
module scc_master_model (
  output logic sclk_o, // Serial clock, idle low
  output logic cs_low_o, // Select, low active
  output logic sdi_o, // Data to device
  input wire logic sdo_i, // Data from device
  input wire logic sdo_oe_i // Device drives line
);
  logic lv; // Last line level seen
  initial begin
    sclk_o = 1'b0;
    cs_low_o = 1'b1;
    sdi_o = 1'b0;
    lv = 1'b0;
  end
  // n clocks of 12 ns, LSB first; answer taken just before each rise
  task frame(input int n, input logic [31:0] d, output logic [15:0] rx);
    rx = 16'h0000;
    #1; // Off the core clock edge
    cs_low_o = 1'b0;
    sdi_o = d[0];
    #6;
    for (int i = 0; i < n; i++) begin
      lv = sdo_oe_i ? sdo_i : ~lv; // Released line is no copy of the last bit
      if (i < 16) rx[i] = lv;
      sclk_o = 1'b1;
      #6;
      sclk_o = 1'b0;
      #1;
      sdi_o = d[(i + 1) % 32]; // Changes only after the sampling fall
      #5;
    end
    cs_low_o = 1'b1;
    sdi_o = ~sdi_o;
  endtask : frame
endmodule : scc_master_model

// ==== tb/tb_top.sv ====
/*
  Top bench for scc_checker: scenario tasks drive the master model and
  the core-side inputs. Assumes package and design compiled first.
*/
`timescale 1ns/1ps
module tb_top;
  logic mclk_i = 1'b0; // Core clock
  logic nrst_i; // Reset, low
  logic restart_done_i = 1'b0; // Restart finished
  logic fail_safe_i = 1'b0; // Fail-safe request
  logic [7:0] wake_event0_i = 8'h00; // Wake pulses
  logic [7:0] wake_event1_i = 8'h00; // Wake pulses
  logic sclk_i, chip_select_low_i, serial_in_i; // From master model
  logic serial_out_o, serial_out_oe_o, cmd_error_o, frame_error_o;
  logic interrupt_out_low_o, wd_trigger_o, soft_reset_o;
  logic [2:0] mode_o;
  logic [7:0] wd_config_o, bus_ctrl_o, wake_ctrl_o, gpio_ctrl_o, timer_ctrl_o;
  logic [5:0] mode_ctrl_o;
  logic [15:0] rx; // Last answer word
  int error_cnt = 0;
  int n_tests = 0;
  int n_int = 0; // Interrupt pulses seen
  int n_trig = 0; // Trigger pulses seen
  int n_srst = 0; // Soft reset pulses seen

  initial begin
    forever #2.5 mclk_i = ~mclk_i;
  end

  scc_checker uut (.mclk_i, .nrst_i, .sclk_i, .chip_select_low_i, .serial_in_i,
    .wake_event0_i, .wake_event1_i, .restart_done_i, .fail_safe_i, .serial_out_o,
    .serial_out_oe_o, .mode_o, .cmd_error_o, .frame_error_o, .interrupt_out_low_o,
    .wd_trigger_o, .soft_reset_o, .wd_config_o, .bus_ctrl_o, .wake_ctrl_o,
    .gpio_ctrl_o, .timer_ctrl_o, .mode_ctrl_o);
  scc_master_model mst (.sclk_o(sclk_i), .cs_low_o(chip_select_low_i),
    .sdi_o(serial_in_i), .sdo_i(serial_out_o), .sdo_oe_i(serial_out_oe_o));

  // Pulse stands one cycle, so every edge is looked at
  always @(posedge mclk_i) begin
    if (interrupt_out_low_o === 1'b0) n_int++;
    if (wd_trigger_o === 1'b1) n_trig++;
    if (soft_reset_o === 1'b1) n_srst++;
  end

  task conclude;
    $display("%0t tests %0d errors %0d", $time, n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : conclude
  task ck(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask : ck
  // One frame, then room for the slow evaluation path
  task xf(input int n, input logic [31:0] d);
    mst.frame(n, d, rx);
    repeat (12) @(posedge mclk_i);
  endtask : xf
  task wr(input logic [6:0] a, input logic [7:0] v);
    xf(16, {16'h0000, v, 1'b1, a});
  endtask : wr
  task rd(input logic [6:0] a);
    xf(16, {16'h0000, 8'h00, 1'b0, a});
  endtask : rd
  task clr;
    wr(scc_pkg::ADDR_DEV_STAT, 8'h01);
    ck(cmd_error_o, 1'b0);
  endtask : clr
  task bad(input logic [6:0] a, input logic [7:0] v);
    wr(a, v);
    ck(cmd_error_o, 1'b1);
    clr();
  endtask : bad
  // Bounded wait for a mode; running out ends the run
  task wm(input logic [2:0] m);
    int i;
    for (i = 0; i < 40 && mode_o !== m; i++) @(posedge mclk_i);
    n_tests++;
    if (i == 40) begin
      error_cnt++;
      $display("Error %0t: mode wait ran out", $time);
      conclude();
    end
  endtask : wm
  task wk(input logic [7:0] e0, input logic [7:0] e1);
    @(posedge mclk_i);
    wake_event0_i <= e0;
    wake_event1_i <= e1;
    @(posedge mclk_i);
    wake_event0_i <= 8'h00;
    wake_event1_i <= 8'h00;
  endtask : wk
  task rs;
    @(posedge mclk_i) restart_done_i <= 1'b1;
    wm(scc_pkg::SCC_NORMAL);
    @(posedge mclk_i) restart_done_i <= 1'b0;
  endtask : rs

  task t_link;
    ck({mode_o, cmd_error_o, interrupt_out_low_o, serial_out_oe_o}, 5'h02);
    wr(scc_pkg::ADDR_BUS, 8'h5a);
    ck(bus_ctrl_o, 8'h5a);
    rd(scc_pkg::ADDR_BUS);
    ck(rx, 16'h5a00);
    xf(32, {16'h1234, 8'h3c, 1'b1, scc_pkg::ADDR_BUS});
    ck(bus_ctrl_o, 8'h3c);
    xf(15, {16'h0000, 8'h77, 1'b1, scc_pkg::ADDR_BUS});
    ck({frame_error_o, bus_ctrl_o}, 9'h13c);
    xf(0, 32'h0000_0000);
    ck({frame_error_o, bus_ctrl_o}, 9'h13c);
    rd(scc_pkg::ADDR_BUS);
    ck({rx[0], frame_error_o}, 2'h2);
    $display("%0t t_link done", $time);
  endtask : t_link
  task t_checks;
    wr(scc_pkg::ADDR_MODE, {scc_pkg::MREQ_STOP, 6'h00});
    ck({mode_o, cmd_error_o}, {scc_pkg::SCC_NORMAL, 1'b1});
    wr(scc_pkg::ADDR_BUS, 8'h11);
    rd(scc_pkg::ADDR_BUS);
    ck({rx[1], cmd_error_o, bus_ctrl_o}, 10'h311);
    clr();
    bad(scc_pkg::ADDR_WD, 8'h03);
    wr(scc_pkg::ADDR_WD, 8'h07);
    ck(16'(n_trig), 16'h0001);
    bad(scc_pkg::ADDR_TIMER, 8'h33);
    wr(scc_pkg::ADDR_TIMER, 8'h25);
    ck({wd_config_o, timer_ctrl_o}, 16'h0725);
    wr(scc_pkg::ADDR_GPIO, 8'h01);
    bad(scc_pkg::ADDR_WAKE1, 8'h80);
    ck({gpio_ctrl_o, wake_ctrl_o}, 16'h0100);
    xf(16, 32'h0000_0000);
    ck(cmd_error_o, 1'b1);
    clr();
    xf(32, 32'hffff_ffff);
    ck(cmd_error_o, 1'b1);
    clr();
    wr(7'h30, 8'h5a);
    ck(cmd_error_o, 1'b0);
    $display("%0t t_checks done", $time);
  endtask : t_checks
  task t_stop;
    int k;
    wr(scc_pkg::ADDR_BUS, 8'h00);
    wr(scc_pkg::ADDR_MODE, {scc_pkg::MREQ_STOP, 6'h00});
    ck({mode_o, cmd_error_o}, {scc_pkg::SCC_STOP, 1'b0});
    bad(scc_pkg::ADDR_BUS, 8'h22);
    ck(bus_ctrl_o, 8'h00);
    wr(scc_pkg::ADDR_MODE, 8'h05);
    ck({mode_o, mode_ctrl_o}, {scc_pkg::SCC_NORMAL, 6'h00});
    clr();
    wk(8'h01, 8'h00);
    k = n_int;
    wr(scc_pkg::ADDR_MODE, {scc_pkg::MREQ_STOP, 6'h00});
    ck({mode_o, cmd_error_o, 4'(n_int - k)}, {scc_pkg::SCC_STOP, 5'h01});
    wr(scc_pkg::ADDR_MODE, {scc_pkg::MREQ_SLEEP, 6'h00});
    ck({mode_o, cmd_error_o}, {scc_pkg::SCC_RESTART, 1'b1});
    rs();
    clr();
    wr(scc_pkg::ADDR_WSTAT0, 8'hff);
    rd(scc_pkg::ADDR_WSTAT0);
    ck(rx, 16'h0000);
    $display("%0t t_stop done", $time);
  endtask : t_stop
  task t_sleep;
    wr(scc_pkg::ADDR_GPIO, 8'h00);
    wr(scc_pkg::ADDR_MODE, {scc_pkg::MREQ_SLEEP, 6'h03});
    ck({mode_o, cmd_error_o, mode_ctrl_o}, {scc_pkg::SCC_RESTART, 7'h43});
    rs();
    clr();
    wr(scc_pkg::ADDR_BUS, 8'h01);
    wr(scc_pkg::ADDR_MODE, {scc_pkg::MREQ_SLEEP, 6'h03});
    ck({mode_o, cmd_error_o}, {scc_pkg::SCC_SLEEP, 1'b0});
    wr(scc_pkg::ADDR_BUS, 8'h02);
    ck(bus_ctrl_o, 8'h01);
    wk(8'h00, 8'h01);
    wm(scc_pkg::SCC_RESTART); // Any wake event leaves sleep
    rs();
    // Timer as only wake source, timer off: straight back out
    wr(scc_pkg::ADDR_BUS, 8'h00);
    wr(scc_pkg::ADDR_WAKE1, 8'h01);
    wr(scc_pkg::ADDR_TIMER, 8'h00);
    wr(scc_pkg::ADDR_MODE, {scc_pkg::MREQ_SLEEP, 6'h03});
    wm(scc_pkg::SCC_RESTART);
    ck(cmd_error_o, 1'b0);
    rs();
    // Soft reset is one of the few commands valid in stop
    wr(scc_pkg::ADDR_MODE, {scc_pkg::MREQ_STOP, 6'h00});
    wr(scc_pkg::ADDR_MODE, {scc_pkg::MREQ_SOFT_RST, 6'h00});
    ck({mode_o, cmd_error_o, 4'(n_srst)}, {scc_pkg::SCC_INIT, 5'h01});
    // Fail-safe shuts the link; frames there change only the frame error flag
    @(posedge mclk_i) fail_safe_i <= 1'b1;
    wm(scc_pkg::SCC_FAILSAFE);
    wr(scc_pkg::ADDR_BUS, 8'h44);
    ck(bus_ctrl_o, 8'h00);
    @(posedge mclk_i) fail_safe_i <= 1'b0;
    wm(scc_pkg::SCC_RESTART);
    rs();
    $display("%0t t_sleep done", $time);
  endtask : t_sleep

  initial begin
    nrst_i <= 1'b0; // A real edge at time zero clears the link toggle
    repeat (2) @(posedge mclk_i);
    nrst_i <= 1'b1;
    repeat (4) @(posedge mclk_i);
    t_link();
    t_checks();
    t_stop();
    t_sleep();
    conclude();
  end
endmodule : tb_top
